// ==== hdl/tml_pkg.sv ====
// Package: register map, field layout and types of the timer 0/1 mode logic
package tml_pkg;

  // ==========================================================
  // Register offsets (word index on the plain register port)
  // ==========================================================
  localparam int          ADDR_W = 4;              // Register address width
  localparam logic [3:0]  A_SCFG = 4'h0;           // system_config
  localparam logic [3:0]  A_TIMER_MODE_SELECT = 4'h1;           // timer_mode_select
  localparam logic [3:0]  A_TCTL = 4'h2;           // timer_control
  localparam logic [3:0]  A_CL0  = 4'h3;           // Timer 0 count_low
  localparam logic [3:0]  A_CH0  = 4'h4;           // Timer 0 count_high
  localparam logic [3:0]  A_CL1  = 4'h5;           // Timer 1 count_low
  localparam logic [3:0]  A_CH1  = 4'h6;           // Timer 1 count_high
  localparam logic [3:0]  A_RL0  = 4'h7;           // Timer 0 reload_low
  localparam logic [3:0]  A_RH0  = 4'h8;           // Timer 0 reload_high
  localparam logic [3:0]  A_RL1  = 4'h9;           // Timer 1 reload_low
  localparam logic [3:0]  A_RH1  = 4'hA;           // Timer 1 reload_high
  localparam logic [3:0]  A_ISTS = 4'hB;           // Interrupt status, write one to clear
  localparam logic [3:0]  A_IMSK = 4'hC;           // Interrupt mask

  // ==========================================================
  // Field positions and masks
  // ==========================================================
  localparam int          SC_PT0  = 2;             // prescale_bit_low
  localparam int          SC_PT1  = 3;             // prescale_bit_high
  localparam logic [7:0]  SC_MASK = 8'h0C;         // Only the prescale bits are kept
  localparam int          TM_ML   = 0;             // mode_bit_low in a timer nibble
  localparam int          TM_CT   = 2;             // Counter select in a timer nibble
  localparam int          TM_GATE = 3;             // Gating bit in a timer nibble
  localparam int          TM_STEP = 4;             // Nibble stride, timer 1 above timer 0
  localparam int          TC_RUN0 = 4;             // run_control of timer 0
  localparam int          TC_OVF0 = 5;             // overflow_flag of timer 0
  localparam int          TC_RUN1 = 6;             // run_control of timer 1
  localparam int          TC_OVF1 = 7;             // overflow_flag of timer 1
  localparam int          TC_STEP = 2;             // Bit stride between timers
  localparam logic [7:0]  TC_MASK = 8'hF0;         // Interrupt-pin bits not held here
  localparam logic [7:0]  RST_VAL = 8'h00;         // Reset value of every register

  // ==========================================================
  // Prescaler (oscillator cycles per tick, minus one)
  // ==========================================================
  localparam logic [5:0]  DIV4_M1  = 6'h03;        // Osc/4
  localparam logic [5:0]  DIV16_M1 = 6'h0F;        // Osc/16
  localparam logic [5:0]  DIV64_M1 = 6'h3F;        // Osc/64
  localparam int          SMP_CYC  = 2;            // Pin sampling period, oscillator cycles

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    PS_DIV4  = 2'h0,
    PS_DIV16 = 2'h1,
    PS_DIV64 = 2'h2,
    PS_RSVD  = 2'h3
  } tml_pres_t;

  typedef enum logic [1:0] {
    MD_AUTO16 = 2'h0,
    MD_FREE16 = 2'h1,
    MD_AUTO8  = 2'h2,
    MD_DUAL8  = 2'h3
  } tml_mode_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                       // Register index
    logic [7:0]        wdata;                      // Write data
    logic              wr;                         // Write strobe
    logic              rd;                         // Read strobe
  } tml_bus_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]       scfg;                        // system_config
    logic [7:0]       timer_mode_select;                        // timer_mode_select
    logic [7:0]       tctl;                        // timer_control
    logic [1:0][15:0] cnt;                         // count_high:count_low per timer
    logic [1:0][15:0] rld;                         // reload_high:reload_low per timer
    logic [1:0]       ists;                        // Sticky overflow events
    logic [1:0]       imsk;                        // Interrupt mask
    logic [5:0]       pre;                         // Prescaler count
    logic             phase;                       // Pin sample phase
    logic [3:0]       s1;                          // Pin sync stage 1
    logic [3:0]       s2;                          // Pin sync stage 2
    logic [3:0]       s3;                          // Pin sync stage 3
    logic [3:0]       filt;                        // Accepted pin levels
    logic [3:0]       smp;                         // Levels at last sample
    logic [7:0]       rdData;                      // Read data
    logic             irq;                         // Interrupt output
  } tml_state_t;

endpackage

// ==== hdl/tml_mode_logic.sv ====
// Module: timer 0/1 mode logic with prescaler, register port and interrupt
//
// Function
// - Counter-select bit picks tick or pin events
// - Two-bit mode field chooses one of four modes
// - Common tick divides oscillator by 4, 16, 64
// - Mode 0 overflow sets flag, reloads both bytes
// - Four writable 8-bit reload registers
// - Mode 2 low byte counts, reloads, high holds
// - Mode 1 counts 16 bits, no reload
// - Mode 0 period is divisor times reload span
// - Mode 2 period is divisor times low span
// - Timer 0 mode 3 high byte uses timer 1 controls
// - Timer 1 in mode 3 holds its count
// - Pin sampled every 2 cycles, falling edges count
//
// Decided for this implementation: the address map and the plain strobed port.
module tml_mode_logic (
  input  wire  logic              clk_sys,         // Oscillator clock
  input  wire  logic              resetn,          // Asynchronous reset, active low
  input  wire  logic              clkEn,           // Freezes all state while low
  input  wire  tml_pkg::tml_bus_t busReq,          // Register port request
  input  wire  logic [1:0]        extCountPin,     // Event inputs, timer 1:0
  input  wire  logic [1:0]        extIntPin,       // external_int_pin gates, timer 1:0
  output logic [7:0]              rdData,          // Read data, cycle after strobe
  output logic [1:0]              ovfFlag,         // overflow_flag copies, timer 1:0
  output logic                    irq              // Level interrupt
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic [1:0] rstSync_ff;                          // Release synchroniser
  logic       rstSync;                             // Reset used by the block

  // Assert at once, release after two edges
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'h1};
  end
  assign rstSync = rstSync_ff[1];

  // ==========================================================
  // Decode
  // ==========================================================
  tml_pkg::tml_state_t st_ff;                      // Registered state
  tml_pkg::tml_state_t nxt_st;                     // Next state
  tml_pkg::tml_pres_t  presCode;                   // Prescale selection
  tml_pkg::tml_mode_t  md [2];                     // Mode per timer
  logic [5:0]          divM1;                      // Tick period minus one
  logic                tick;                       // Common timer_tick
  logic [1:0]          fallEv;                     // Sampled falling edges
  logic [1:0]          inc;                        // Count enable per timer
  logic                hiInc;                      // Timer 0 high byte step in mode 3
  logic [1:0]          ovSet;                      // Overflow events this cycle

  assign presCode = tml_pkg::tml_pres_t'(st_ff.scfg[tml_pkg::SC_PT1:tml_pkg::SC_PT0]);
  assign divM1 = (presCode == tml_pkg::PS_DIV4)  ? tml_pkg::DIV4_M1  :
                 (presCode == tml_pkg::PS_DIV16) ? tml_pkg::DIV16_M1 : tml_pkg::DIV64_M1;
  // Reserved code stops the tick rather than guess a rate
  assign tick = (presCode != tml_pkg::PS_RSVD) && (st_ff.pre >= divM1);
  // Falling edge seen between two samples, 2 cycles apart
  assign fallEv = {2{st_ff.phase}} & st_ff.smp[1:0] & ~st_ff.filt[1:0];

  // Per-timer count enables
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      md[i]  = tml_pkg::tml_mode_t'(st_ff.timer_mode_select[tml_pkg::TM_STEP*i+tml_pkg::TM_ML +: 2]);
      inc[i] = st_ff.tctl[tml_pkg::TC_RUN0+tml_pkg::TC_STEP*i]
               && (!st_ff.timer_mode_select[tml_pkg::TM_STEP*i+tml_pkg::TM_GATE] || st_ff.filt[2+i])
               && (st_ff.timer_mode_select[tml_pkg::TM_STEP*i+tml_pkg::TM_CT] ? fallEv[i] : tick);
    end
    // Timer 1 mode 3 acts as a cleared run bit
    if (md[1] == tml_pkg::MD_DUAL8)
      inc[1] = 1'h0;
    // High byte is a plain timer on timer 1's run bit
    hiInc = (md[0] == tml_pkg::MD_DUAL8) && st_ff.tctl[tml_pkg::TC_RUN1] && tick;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdData = 8'h00;
    ovSet = 2'h0;

    // Three-stage pin sync; accept a level when stages 2 and 3 agree
    nxt_st.s1 = {extIntPin, extCountPin};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.filt = (st_ff.s2 & st_ff.s3) | (st_ff.filt & (st_ff.s2 ^ st_ff.s3));

    // Sample every second oscillator cycle
    nxt_st.phase = ~st_ff.phase;
    if (st_ff.phase)
      nxt_st.smp = st_ff.filt;

    // Prescaler; held at zero when reserved
    if (tick || presCode == tml_pkg::PS_RSVD)
      nxt_st.pre = 6'h00;
    else
      nxt_st.pre = st_ff.pre + 6'h01;

    // Counting, one step per enabled event
    for (int i = 0; i < 2; i++)
    begin
      if (inc[i])
      begin
        unique case (md[i])
          tml_pkg::MD_AUTO16:
          begin
            // Period: divisor times (65536 - reload)
            if (st_ff.cnt[i] == 16'hFFFF)
            begin
              nxt_st.cnt[i] = st_ff.rld[i];
              ovSet[i] = 1'h1;
            end
            else
              nxt_st.cnt[i] = st_ff.cnt[i] + 16'h0001;
          end
          tml_pkg::MD_FREE16:
          begin
            // Plain wrap, no reload
            nxt_st.cnt[i] = st_ff.cnt[i] + 16'h0001;
            ovSet[i] = (st_ff.cnt[i] == 16'hFFFF);
          end
          tml_pkg::MD_AUTO8:
          begin
            // Period: divisor times (256 - low reload); high byte untouched
            if (st_ff.cnt[i][7:0] == 8'hFF)
            begin
              nxt_st.cnt[i][7:0] = st_ff.rld[i][7:0];
              ovSet[i] = 1'h1;
            end
            else
              nxt_st.cnt[i][7:0] = st_ff.cnt[i][7:0] + 8'h01;
          end
          tml_pkg::MD_DUAL8:
          begin
            // Low byte: free 8-bit count on timer 0 controls
            nxt_st.cnt[i][7:0] = st_ff.cnt[i][7:0] + 8'h01;
            ovSet[i] = (st_ff.cnt[i][7:0] == 8'hFF);
          end
        endcase
      end
    end

    // Timer 0 mode 3 high byte owns timer 1's flag
    if (md[0] == tml_pkg::MD_DUAL8)
    begin
      ovSet[1] = hiInc && (st_ff.cnt[0][15:8] == 8'hFF);
      if (hiInc)
        nxt_st.cnt[0][15:8] = st_ff.cnt[0][15:8] + 8'h01;
    end

    // Software writes; a count write overrides the step
    if (busReq.wr)
    begin
      case (busReq.addr)
        tml_pkg::A_SCFG: nxt_st.scfg = busReq.wdata & tml_pkg::SC_MASK;
        tml_pkg::A_TIMER_MODE_SELECT: nxt_st.timer_mode_select = busReq.wdata;
        tml_pkg::A_TCTL: nxt_st.tctl = busReq.wdata & tml_pkg::TC_MASK;
        tml_pkg::A_CL0:  nxt_st.cnt[0][7:0]  = busReq.wdata;
        tml_pkg::A_CH0:  nxt_st.cnt[0][15:8] = busReq.wdata;
        tml_pkg::A_CL1:  nxt_st.cnt[1][7:0]  = busReq.wdata;
        tml_pkg::A_CH1:  nxt_st.cnt[1][15:8] = busReq.wdata;
        tml_pkg::A_RL0:  nxt_st.rld[0][7:0]  = busReq.wdata;
        tml_pkg::A_RH0:  nxt_st.rld[0][15:8] = busReq.wdata;
        tml_pkg::A_RL1:  nxt_st.rld[1][7:0]  = busReq.wdata;
        tml_pkg::A_RH1:  nxt_st.rld[1][15:8] = busReq.wdata;
        tml_pkg::A_ISTS: nxt_st.ists = st_ff.ists & ~busReq.wdata[1:0];
        tml_pkg::A_IMSK: nxt_st.imsk = busReq.wdata[1:0];
        default: ;                                 // Unmapped: ignored
      endcase
    end

    // Hardware set wins over a same-cycle software clear
    nxt_st.tctl[tml_pkg::TC_OVF0] = nxt_st.tctl[tml_pkg::TC_OVF0] | ovSet[0];
    nxt_st.tctl[tml_pkg::TC_OVF1] = nxt_st.tctl[tml_pkg::TC_OVF1] | ovSet[1];
    nxt_st.ists = nxt_st.ists | ovSet;
    nxt_st.irq = |(nxt_st.ists & nxt_st.imsk);

    // Reads answer next cycle; unmapped reads zero
    if (busReq.rd)
    begin
      case (busReq.addr)
        tml_pkg::A_SCFG: nxt_st.rdData = st_ff.scfg;
        tml_pkg::A_TIMER_MODE_SELECT: nxt_st.rdData = st_ff.timer_mode_select;
        tml_pkg::A_TCTL: nxt_st.rdData = st_ff.tctl;
        tml_pkg::A_CL0:  nxt_st.rdData = st_ff.cnt[0][7:0];
        tml_pkg::A_CH0:  nxt_st.rdData = st_ff.cnt[0][15:8];
        tml_pkg::A_CL1:  nxt_st.rdData = st_ff.cnt[1][7:0];
        tml_pkg::A_CH1:  nxt_st.rdData = st_ff.cnt[1][15:8];
        tml_pkg::A_RL0:  nxt_st.rdData = st_ff.rld[0][7:0];
        tml_pkg::A_RH0:  nxt_st.rdData = st_ff.rld[0][15:8];
        tml_pkg::A_RL1:  nxt_st.rdData = st_ff.rld[1][7:0];
        tml_pkg::A_RH1:  nxt_st.rdData = st_ff.rld[1][15:8];
        tml_pkg::A_ISTS: nxt_st.rdData = {6'h00, st_ff.ists};
        tml_pkg::A_IMSK: nxt_st.rdData = {6'h00, st_ff.imsk};
        default:         nxt_st.rdData = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Clock enable freezes everything, pin sync included
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      st_ff <= '0;
    else if (clkEn)
      st_ff <= nxt_st;
  end

  assign rdData  = st_ff.rdData;
  assign ovfFlag = {st_ff.tctl[tml_pkg::TC_OVF1], st_ff.tctl[tml_pkg::TC_OVF0]};
  assign irq     = st_ff.irq;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync);

  property p_pre_step;
    (clkEn && !tick && presCode != tml_pkg::PS_RSVD) |=> st_ff.pre == $past(st_ff.pre) + 6'h01;
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("prescaler did not step");

  property p_rsvd;
    (presCode == tml_pkg::PS_RSVD) |-> !tick;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("tick on reserved prescale");

  property p_auto16;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_AUTO16 && st_ff.cnt[0] == 16'hFFFF)
      |=> (st_ff.cnt[0] == $past(st_ff.rld[0])) && st_ff.tctl[tml_pkg::TC_OVF0];
  endproperty
  a_auto16: assert property (p_auto16) else $error("mode 0 reload missed");

  property p_auto8;
    (clkEn && !busReq.wr && inc[1] && md[1] == tml_pkg::MD_AUTO8
     && md[0] != tml_pkg::MD_DUAL8 && st_ff.cnt[1][7:0] == 8'hFF)
      |=> (st_ff.cnt[1][7:0] == $past(st_ff.rld[1][7:0])) && $stable(st_ff.cnt[1][15:8])
          && st_ff.tctl[tml_pkg::TC_OVF1];
  endproperty
  a_auto8: assert property (p_auto8) else $error("mode 2 reload wrong");

  property p_free16;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_FREE16 && st_ff.cnt[0] == 16'hFFFF)
      |=> (st_ff.cnt[0] == 16'h0000) && st_ff.tctl[tml_pkg::TC_OVF0];
  endproperty
  a_free16: assert property (p_free16) else $error("mode 1 wrap wrong");

  property p_hold1;
    (md[1] == tml_pkg::MD_DUAL8 && !busReq.wr) |=> $stable(st_ff.cnt[1]);
  endproperty
  a_hold1: assert property (p_hold1) else $error("timer 1 moved in mode 3");

  property p_run;
    (!st_ff.tctl[tml_pkg::TC_RUN0] && md[0] != tml_pkg::MD_DUAL8 && !busReq.wr)
      |=> $stable(st_ff.cnt[0]);
  endproperty
  a_run: assert property (p_run) else $error("timer 0 counted while stopped");

  property p_gate;
    (st_ff.timer_mode_select[tml_pkg::TM_GATE] && !st_ff.filt[2]) |-> !inc[0];
  endproperty
  a_gate: assert property (p_gate) else $error("gated timer counted");

  property p_fall;
    (st_ff.timer_mode_select[tml_pkg::TM_CT] && inc[0]) |-> st_ff.phase && st_ff.smp[0] && !st_ff.filt[0];
  endproperty
  a_fall: assert property (p_fall) else $error("count without falling edge");

  property p_timer_src;
    (!st_ff.timer_mode_select[tml_pkg::TM_CT] && !tick) |-> !inc[0];
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("timer stepped without tick");

  property p_hi8;
    (clkEn && !busReq.wr && hiInc && st_ff.cnt[0][15:8] == 8'hFF)
      |=> (st_ff.cnt[0][15:8] == 8'h00) && st_ff.tctl[tml_pkg::TC_OVF1];
  endproperty
  a_hi8: assert property (p_hi8) else $error("mode 3 high byte flag missed");

  // ==========================================================
  // Single steps, held flags and reload writes
  // ==========================================================
  // Shortest divisor is four, so ticks never come closer
  property p_tick_gap;
    (clkEn && tick) |=> !tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than four cycles");

  property p_auto8_t0;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_AUTO8
     && st_ff.cnt[0][7:0] == 8'hFF)
      |=> (st_ff.cnt[0][7:0] == $past(st_ff.rld[0][7:0])) && $stable(st_ff.cnt[0][15:8])
          && st_ff.tctl[tml_pkg::TC_OVF0];
  endproperty
  a_auto8_t0: assert property (p_auto8_t0) else $error("timer 0 mode 2 reload wrong");

  property p_step16;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_AUTO16 && st_ff.cnt[0] != 16'hFFFF)
      |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 16'h0001;
  endproperty
  a_step16: assert property (p_step16) else $error("mode 0 step not one");

  property p_step_free;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_FREE16)
      |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 16'h0001;
  endproperty
  a_step_free: assert property (p_step_free) else $error("mode 1 step or wrap wrong");

  property p_lo8;
    (clkEn && !busReq.wr && inc[0] && md[0] == tml_pkg::MD_DUAL8)
      |=> st_ff.cnt[0][7:0] == $past(st_ff.cnt[0][7:0]) + 8'h01;
  endproperty
  a_lo8: assert property (p_lo8) else $error("mode 3 low byte step wrong");

  property p_rld_wr;
    (clkEn && busReq.wr && busReq.addr == tml_pkg::A_RH0)
      |=> st_ff.rld[0][15:8] == $past(busReq.wdata);
  endproperty
  a_rld_wr: assert property (p_rld_wr) else $error("reload write lost");

  // Flag stays until software writes the control register
  property p_ovf_hold;
    (st_ff.tctl[tml_pkg::TC_OVF0] && !(busReq.wr && busReq.addr == tml_pkg::A_TCTL))
      |=> st_ff.tctl[tml_pkg::TC_OVF0];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");

  c_auto16: cover property (inc[0] && md[0] == tml_pkg::MD_AUTO16 && st_ff.cnt[0] == 16'hFFFF);
  c_hi8:    cover property (hiInc && st_ff.cnt[0][15:8] == 8'hFF);
  c_event:  cover property (st_ff.timer_mode_select[tml_pkg::TM_CT] && inc[0] ##1 irq);
  c_auto8:  cover property (inc[0] && md[0] == tml_pkg::MD_AUTO8 && st_ff.cnt[0][7:0] == 8'hFF);
  c_free16: cover property (inc[0] && md[0] == tml_pkg::MD_FREE16 && st_ff.cnt[0] == 16'hFFFF);

endmodule // tml_mode_logic

// ==== test/tb_tml_mode_logic.sv ====
// Testbench: self-checking regression of the timer 0/1 mode logic
module tb_tml_mode_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  // ==========================================================
  logic              clk_sys;        // Oscillator clock
  logic              resetn;         // Reset, active low
  logic              clkEn;          // Clock enable, tied on
  tml_pkg::tml_bus_t busReq;         // Register port request
  logic [1:0]        extCountPin;    // Event inputs
  logic [1:0]        extIntPin;      // Gate inputs
  logic [7:0]        rdData;         // Read data
  logic [1:0]        ovfFlag;        // Overflow flags
  logic              irq;            // Interrupt
  int                fail_count;     // Mismatches
  int                samples_checked;// Comparisons
  int                cycles;         // Cycle counter for timeout
  logic [7:0]        v;              // Read value
  logic [31:0]       per;            // Measured period
  int                rl;             // Model reload value
  int                n;              // Model event count
  tml_mode_logic tml_mode_logic_inst (
    .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .busReq(busReq),
    .extCountPin(extCountPin), .extIntPin(extIntPin), .rdData(rdData),
    .ovfFlag(ovfFlag), .irq(irq)
  );
  // ==========================================================
  // Clock and timeout
  // ==========================================================
  always #12.5 clk_sys = ~clk_sys;
  // A hang counts as a mismatch and ends the run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic stop_test();
    $display("Checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compare seen against model value
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    // Take the data mid-cycle, while it stands
    @(negedge clk_sys);
    d = rdData;
    @(posedge clk_sys);
  endtask
  // Bounded wait for an overflow flag
  task automatic wait_flag(input int ch);
    int k;
    k = 0;
    // Looked at mid-cycle; returns there so the caller reads settled values
    do
    begin
      @(negedge clk_sys);
      k++;
    end
    while (ovfFlag[ch] !== 1'b1 && k < 5000);
    check("overflow flag", ovfFlag[ch], 1'b1);
  endtask
  // Cycles between two flag sets, flag cleared in between
  task automatic period(input int ch, output logic [31:0] c);
    int t0;
    wait_flag(ch);
    t0 = cycles;
    wr(tml_pkg::A_TCTL, ch ? 8'h40 : 8'h10);
    wait_flag(ch);
    c = cycles - t0;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    clkEn = 1'b1;
    busReq = '0;
    extCountPin = 2'h0;
    extIntPin = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'h2dfa));
    idle(20);
    resetn <= 1'b1;
    idle(4);
    // Reset values, unmapped index reads zero
    for (int a = 0; a < 14; a++)
    begin
      rd(a[3:0], v);
      check("reset value", v, 8'h00);
    end
    wr(tml_pkg::A_SCFG, 8'hFF);
    rd(tml_pkg::A_SCFG, v);
    check("system_config", v, 8'h0C);
    for (int a = 7; a < 11; a++)
    begin
      rl = $urandom % 256;
      wr(a[3:0], rl[7:0]);
      rd(a[3:0], v);
      check("reload reg", v, rl[7:0]);
    end
    $display("Test registers done");
    // Mode 0 period for every divisor, reload of both bytes
    for (int p = 0; p < 3; p++)
    begin
      wr(tml_pkg::A_SCFG, 8'(p << 2));
      wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h00);
      wr(tml_pkg::A_RL0, 8'hF0);
      wr(tml_pkg::A_RH0, 8'hFF);
      wr(tml_pkg::A_CL0, 8'hF0);
      wr(tml_pkg::A_CH0, 8'hFF);
      wr(tml_pkg::A_TCTL, 8'h10);
      period(0, per);
      check("mode0 period", per, (4 << (2 * p)) * 16);
      wr(tml_pkg::A_TCTL, 8'h00);
      rd(tml_pkg::A_CH0, v);
      check("mode0 high reloaded", v, 8'hFF);
    end
    $display("Test mode 0 done");
    // Mode 2 period, high byte untouched
    rl = 32'hC0 | ($urandom % 64);
    wr(tml_pkg::A_SCFG, 8'h04);
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h02);
    wr(tml_pkg::A_RL0, rl[7:0]);
    wr(tml_pkg::A_CL0, rl[7:0]);
    wr(tml_pkg::A_CH0, 8'h55);
    wr(tml_pkg::A_TCTL, 8'h10);
    period(0, per);
    check("mode2 period", per, 16 * (256 - rl));
    wr(tml_pkg::A_TCTL, 8'h00);
    rd(tml_pkg::A_CH0, v);
    check("mode2 high held", v, 8'h55);
    $display("Test mode 2 done");
    // Mode 1 wrap without reload, then status, mask and interrupt
    wr(tml_pkg::A_ISTS, 8'h03);
    wr(tml_pkg::A_SCFG, 8'h00);
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h01);
    wr(tml_pkg::A_RH0, 8'h12);
    wr(tml_pkg::A_CL0, 8'hFE);
    wr(tml_pkg::A_CH0, 8'hFF);
    wr(tml_pkg::A_TCTL, 8'h10);
    wait_flag(0);
    wr(tml_pkg::A_TCTL, 8'h20);
    rd(tml_pkg::A_CH0, v);
    check("mode1 wrapped high", v, 8'h00);
    rd(tml_pkg::A_TCTL, v);
    check("mode1 flag", v, 8'h20);
    rd(tml_pkg::A_ISTS, v);
    check("status", v, 8'h01);
    check("irq masked", irq, 1'b0);
    wr(tml_pkg::A_IMSK, 8'h01);
    idle(2);
    check("irq unmasked", irq, 1'b1);
    wr(tml_pkg::A_ISTS, 8'h01);
    idle(2);
    check("irq cleared", irq, 1'b0);
    $display("Test mode 1 done");
    // Gate low blocks, gate high counts, reserved prescale stops
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h08);
    wr(tml_pkg::A_CL0, 8'h00);
    wr(tml_pkg::A_TCTL, 8'h10);
    idle(100);
    rd(tml_pkg::A_CL0, v);
    check("gated off", v, 8'h00);
    extIntPin <= 2'h1;
    idle(100);
    rd(tml_pkg::A_CL0, v);
    check("gated on", v != 8'h00, 1'b1);
    wr(tml_pkg::A_SCFG, 8'h0C);
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h00);
    wr(tml_pkg::A_CL0, 8'h00);
    idle(100);
    rd(tml_pkg::A_CL0, v);
    check("reserved prescale", v, 8'h00);
    $display("Test gate done");
    // Counter mode, one count per falling edge
    n = 1 + $urandom % 8;
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h04);
    wr(tml_pkg::A_CL0, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      extCountPin <= 2'h1;
      idle(6);
      extCountPin <= 2'h0;
      idle(6);
    end
    idle(10);
    rd(tml_pkg::A_CL0, v);
    check("event count", v, n[7:0]);
    $display("Test counter done");
    // Timer 0 split, timer 1 held in mode 3
    wr(tml_pkg::A_TCTL, 8'h00);
    wr(tml_pkg::A_SCFG, 8'h00);
    wr(tml_pkg::A_TIMER_MODE_SELECT, 8'h33);
    wr(tml_pkg::A_CL0, 8'h00);
    wr(tml_pkg::A_CH0, 8'hF0);
    wr(tml_pkg::A_CL1, 8'h77);
    wr(tml_pkg::A_TCTL, 8'h40);
    wait_flag(1);
    check("high byte ovf", ovfFlag, 2'h2);
    wr(tml_pkg::A_TCTL, 8'h00);
    rd(tml_pkg::A_CL0, v);
    check("low byte idle", v, 8'h00);
    rd(tml_pkg::A_CL1, v);
    check("timer1 held", v, 8'h77);
    $display("Test mode 3 done");
    stop_test();
  end
endmodule // tb_tml_mode_logic
